// ---- common/bsc_link_if.sv ----
`timescale 1ns/1ps
interface bsc_link_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe_n;
    logic sda_dev_o;
    logic sda_dev_oe_n;
    logic sda;
    // open-drain wire with pull-up
    assign sda = (sda_host_oe_n | sda_host_o) & (sda_dev_oe_n | sda_dev_o);
    modport host(
        output scl,
        output sda_host_o,
        output sda_host_oe_n,
        input sda
    );
    modport dev(
        input scl,
        input sda,
        output sda_dev_o,
        output sda_dev_oe_n
    );
endinterface

// ---- common/bsc_pkg.sv ----
package bsc_pkg;

    localparam logic [6:0] DEV_ADDR = 7'h76;
    localparam logic [7:0] CMD_SRST = 8'h06;
    localparam logic [7:0] CMD_TP = 8'h10;
    localparam logic [7:0] CMD_TA = 8'h11;
    localparam logic [7:0] CMD_P = 8'h30;
    localparam logic [7:0] CMD_A = 8'h31;
    localparam logic [7:0] CMD_T = 8'h32;
    localparam logic [7:0] CMD_CAL = 8'h28;
    localparam logic [2:0] CVT_PFX = 3'h2;
    localparam logic [2:0] OSR_MAX = 3'h5;
    localparam logic [1:0] CH_TP = 2'h0;
    localparam logic [1:0] CH_T = 2'h2;
    localparam logic [1:0] REG_RD = 2'h2;
    localparam logic [1:0] REG_WR = 2'h3;
    localparam int RES_W = 20;
    localparam int FLD_W = 24;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int CLK_MHZ = 200;
    localparam int SCL_KHZ = 400;
    localparam int SCL_QTR = CLK_MHZ * 1000 / (SCL_KHZ * 4);
    localparam int PWRUP_US = 400;
    localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
    localparam int CAL_US = 100;
    localparam int CAL_CYC = CAL_US * CLK_MHZ;

    typedef enum {LS_IDLE, LS_ADDR, LS_CMD, LS_WDATA, LS_READ} bsc_lstate_t;
    typedef enum {SEL_NONE, SEL_P, SEL_A, SEL_T, SEL_TP, SEL_TA, SEL_REG} bsc_sel_t;
    typedef enum {DS_PWRUP, DS_SLEEP, DS_CAL, DS_CONV} bsc_dstate_t;
    typedef enum logic [1:0] {KD_CMD, KD_WREG, KD_READ} bsc_kind_t;
    typedef enum {HS_IDLE, HS_START, HS_BIT, HS_STOP} bsc_hstate_t;
endpackage

// ---- core/bsc_dev.sv ----
`timescale 1ns/1ps
module bsc_dev #(
    parameter int PWRUP_N = bsc_pkg::PWRUP_CYC,
    parameter int CAL_N = bsc_pkg::CAL_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    bsc_link_if.dev link,
    input wire logic result_valid,
    input wire logic [bsc_pkg::RES_W-1:0] result_temp,
    input wire logic [bsc_pkg::RES_W-1:0] result_press,
    input wire logic [bsc_pkg::RES_W-1:0] result_alt,
    output logic conv_start,
    output logic [2:0] conv_osr,
    output logic conv_temp_only,
    output logic conv_fail,
    output logic recal_busy,
    output logic dev_ready
);
    import bsc_pkg::*;

    // ---------------- link domain, clocked by scl ----------------
    logic start_tg_q;
    logic seen_q, seen_d;
    bsc_lstate_t ls_q, ls_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic ack_q, ack_d;
    bsc_sel_t sel_q, sel_d;
    logic [5:0] raddr_q, raddr_d;
    logic [7:0] cmd_q, cmd_d;
    logic cmd_tg_q, cmd_tg_d;
    logic act_q, act_d;
    logic [47:0] rd_q, rd_d;
    logic [7:0] regs_q [0:63];
    logic [7:0] regs_d [0:63];
    logic drv_q;
    logic [7:0] byte_in;
    logic [47:0] img;
    logic [FLD_W-1:0] snap_t, snap_p, snap_a;
    logic [3*RES_W-1:0] snap_q, snap_d;

    // start: sda falls while scl is high
    always_ff @(negedge link.sda or negedge nrst) begin
        if (!nrst) begin
            start_tg_q <= 1'b0;
        end else if (link.scl) begin
            start_tg_q <= ~start_tg_q;
        end
    end

    // top four bits carry the sign
    assign snap_t = {{4{snap_q[59]}}, snap_q[59:40]};
    assign snap_p = {{4{snap_q[39]}}, snap_q[39:20]};
    assign snap_a = {{4{snap_q[19]}}, snap_q[19:0]};

    // read image, high byte leaves first
    always_comb begin
        case (sel_q)
            SEL_P: img = {snap_p, 24'h0};
            SEL_A: img = {snap_a, 24'h0};
            SEL_T: img = {snap_t, 24'h0};
            SEL_TP: img = {snap_t, snap_p};
            SEL_TA: img = {snap_t, snap_a};
            SEL_REG: img = {regs_q[raddr_q], 40'h0};
            default: img = 48'h0;
        endcase
    end

    always_comb begin
        byte_in = {sh_q[6:0], link.sda};
        seen_d = start_tg_q;
        ls_d = ls_q;
        bit_d = bit_q;
        sh_d = sh_q;
        ack_d = ack_q;
        sel_d = sel_q;
        raddr_d = raddr_q;
        cmd_d = cmd_q;
        cmd_tg_d = cmd_tg_q;
        rd_d = rd_q;
        regs_d = regs_q;
        if (start_tg_q != seen_q) begin
            // this edge samples address bit 6
            ls_d = LS_ADDR;
            bit_d = 4'h1;
            sh_d = byte_in;
            ack_d = 1'b0;
        end else if (bit_q != 4'h8) begin
            sh_d = byte_in;
            bit_d = bit_q + 4'h1;
            rd_d = {rd_q[46:0], 1'b0};
            if (bit_q == 4'h7) begin
                case (ls_q)
                    LS_ADDR: begin
                        if (byte_in[7:1] == DEV_ADDR) begin
                            ack_d = 1'b1;
                            ls_d = byte_in[0] ? LS_READ : LS_CMD;
                            rd_d = img;
                        end else begin
                            ls_d = LS_IDLE;
                        end
                    end
                    LS_CMD: begin
                        ls_d = LS_IDLE;
                        ack_d = 1'b1;
                        case (byte_in)
                            CMD_SRST: begin
                                cmd_d = byte_in;
                                cmd_tg_d = ~cmd_tg_q;
                                sel_d = SEL_NONE;
                                for (int i = 0; i < 64; i++) begin
                                    regs_d[i] = REG_RST;
                                end
                            end
                            CMD_CAL: begin
                                cmd_d = byte_in;
                                cmd_tg_d = ~cmd_tg_q;
                            end
                            CMD_TP: sel_d = SEL_TP;
                            CMD_TA: sel_d = SEL_TA;
                            CMD_P: sel_d = SEL_P;
                            CMD_A: sel_d = SEL_A;
                            CMD_T: sel_d = SEL_T;
                            default: begin
                                if (byte_in[7:6] == REG_WR) begin
                                    raddr_d = byte_in[5:0];
                                    ls_d = LS_WDATA;
                                end else if (byte_in[7:6] == REG_RD) begin
                                    raddr_d = byte_in[5:0];
                                    sel_d = SEL_REG;
                                end else if (byte_in[7:5] == CVT_PFX) begin
                                    cmd_d = byte_in;
                                    cmd_tg_d = ~cmd_tg_q;
                                end else begin
                                    ack_d = 1'b0;
                                end
                            end
                        endcase
                    end
                    LS_WDATA: begin
                        regs_d[raddr_q] = byte_in;
                        ack_d = 1'b1;
                        ls_d = LS_IDLE;
                    end
                    default: begin
                    end
                endcase
            end
        end else begin
            // ninth clock: acknowledge slot
            bit_d = 4'h0;
            ack_d = 1'b0;
            if (ls_q == LS_READ && !ack_q && link.sda) begin
                ls_d = LS_IDLE;
            end
        end
        act_d = (ls_d != LS_IDLE);
    end

    always_ff @(posedge link.scl or negedge nrst) begin
        if (!nrst) begin
            seen_q <= 1'b0;
            ls_q <= LS_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ack_q <= 1'b0;
            sel_q <= SEL_NONE;
            raddr_q <= 6'h00;
            cmd_q <= 8'h00;
            cmd_tg_q <= 1'b0;
            act_q <= 1'b0;
            rd_q <= 48'h0;
            for (int i = 0; i < 64; i++) begin
                regs_q[i] <= REG_RST;
            end
        end else begin
            seen_q <= seen_d;
            ls_q <= ls_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            ack_q <= ack_d;
            sel_q <= sel_d;
            raddr_q <= raddr_d;
            cmd_q <= cmd_d;
            cmd_tg_q <= cmd_tg_d;
            act_q <= act_d;
            rd_q <= rd_d;
            regs_q <= regs_d;
        end
    end

    // sda changes only while scl is low
    always_ff @(negedge link.scl or negedge nrst) begin
        if (!nrst) begin
            drv_q <= 1'b0;
        end else begin
            drv_q <= (bit_q == 4'h8 && ack_q) ||
                (ls_q == LS_READ && bit_q != 4'h8 && !rd_q[47]);
        end
    end

    assign link.sda_dev_o = 1'b0;
    assign link.sda_dev_oe_n = ~drv_q;

    // ---------------- core domain, clocked by ref_clk ----------------
    logic cmd_s1, cmd_s2, cmd_s3;
    logic act_s1, act_s2;
    bsc_dstate_t ds_q, ds_d;
    logic [31:0] cnt_q, cnt_d;
    logic [3*RES_W-1:0] in_q, in_d;
    logic pend_q, pend_d;
    logic cs_q, cs_d;
    logic cf_q, cf_d;
    logic [2:0] osr_q, osr_d;
    logic to_q, to_d;
    logic cmd_ev;

    assign cmd_ev = cmd_s2 != cmd_s3;

    always_comb begin
        ds_d = ds_q;
        cnt_d = cnt_q;
        in_d = in_q;
        pend_d = pend_q;
        snap_d = snap_q;
        cs_d = 1'b0;
        cf_d = 1'b0;
        osr_d = osr_q;
        to_d = to_q;
        // results move to the snapshot only while no frame runs
        if (pend_q && !act_s2) begin
            snap_d = in_q;
            pend_d = 1'b0;
        end
        if (result_valid) begin
            in_d = {result_temp, result_press, result_alt};
            pend_d = 1'b1;
        end
        case (ds_q)
            DS_PWRUP: begin
                cnt_d = cnt_q + 32'd1;
                if (cnt_q == 32'(PWRUP_N - 1)) begin
                    ds_d = DS_SLEEP;
                    cnt_d = 32'd0;
                end
            end
            DS_CAL: begin
                cnt_d = cnt_q + 32'd1;
                if (cnt_q == 32'(CAL_N - 1)) begin
                    ds_d = DS_SLEEP;
                    cnt_d = 32'd0;
                end
            end
            DS_SLEEP: begin
                if (cmd_ev && cmd_q == CMD_CAL) begin
                    ds_d = DS_CAL;
                end else if (cmd_ev && cmd_q[7:5] == CVT_PFX) begin
                    if (cmd_q[4:2] <= OSR_MAX &&
                        (cmd_q[1:0] == CH_TP || cmd_q[1:0] == CH_T)) begin
                        cs_d = 1'b1;
                        osr_d = cmd_q[4:2];
                        to_d = (cmd_q[1:0] == CH_T);
                        ds_d = DS_CONV;
                    end else begin
                        cf_d = 1'b1;
                    end
                end
            end
            DS_CONV: begin
                if (result_valid) begin
                    ds_d = DS_SLEEP;
                end
            end
            default: ds_d = DS_PWRUP;
        endcase
        if (cmd_ev && cmd_q == CMD_SRST) begin
            ds_d = DS_PWRUP;
            cnt_d = 32'd0;
            in_d = '0;
            snap_d = '0;
            pend_d = 1'b0;
            cs_d = 1'b0;
            cf_d = 1'b0;
            osr_d = 3'h0;
            to_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_s1 <= 1'b0;
            cmd_s2 <= 1'b0;
            cmd_s3 <= 1'b0;
            act_s1 <= 1'b0;
            act_s2 <= 1'b0;
            ds_q <= DS_PWRUP;
            cnt_q <= 32'd0;
            in_q <= '0;
            snap_q <= '0;
            pend_q <= 1'b0;
            cs_q <= 1'b0;
            cf_q <= 1'b0;
            osr_q <= 3'h0;
            to_q <= 1'b0;
        end else begin
            cmd_s1 <= cmd_tg_q;
            cmd_s2 <= cmd_s1;
            cmd_s3 <= cmd_s2;
            act_s1 <= act_q;
            act_s2 <= act_s1;
            ds_q <= ds_d;
            cnt_q <= cnt_d;
            in_q <= in_d;
            snap_q <= snap_d;
            pend_q <= pend_d;
            cs_q <= cs_d;
            cf_q <= cf_d;
            osr_q <= osr_d;
            to_q <= to_d;
        end
    end

    assign conv_start = cs_q;
    assign conv_fail = cf_q;
    assign conv_osr = osr_q;
    assign conv_temp_only = to_q;
    assign recal_busy = (ds_q == DS_CAL);
    assign dev_ready = (ds_q == DS_SLEEP);
endmodule

// ---- core/bsc_host.sv ----
`timescale 1ns/1ps
module bsc_host #(
    parameter int QTR_N = bsc_pkg::SCL_QTR
) (
    input wire logic ref_clk,
    input wire logic nrst,
    bsc_link_if.host link,
    input wire logic req,
    input wire bsc_pkg::bsc_kind_t req_kind,
    input wire logic [7:0] req_cmd,
    input wire logic [7:0] req_wdata,
    input wire logic [2:0] req_len,
    output logic busy,
    output logic done,
    output logic nack,
    output logic [47:0] rd_data,
    output logic signed [31:0] temp_deg
);
    import bsc_pkg::*;

    bsc_hstate_t hs_q, hs_d;
    bsc_kind_t kind_q, kind_d;
    logic [6:0] qc_q, qc_d;
    logic [1:0] ph_q, ph_d;
    logic scl_q, scl_d;
    logic sdo_q, sdo_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] bit_q, bit_d;
    logic [2:0] byte_q, byte_d;
    logic [7:0] cmd_q, cmd_d;
    logic [7:0] wd_q, wd_d;
    logic [2:0] len_q, len_d;
    logic nack_q, nack_d;
    logic [47:0] rd_q, rd_d;
    logic done_q, done_d;
    logic signed [31:0] td_q, td_d;
    logic s1, s2;
    logic tick, wr, last;
    logic [2:0] last_idx;
    logic [RES_W-1:0] tv;

    always_comb begin
        tick = (qc_q == 7'(QTR_N - 1));
        wr = (byte_q == 3'h0) || (kind_q != KD_READ);
        case (kind_q)
            KD_CMD: last_idx = 3'h1;
            KD_WREG: last_idx = 3'h2;
            default: last_idx = len_q;
        endcase
        last = (byte_q == last_idx);
        tv = (len_q == 3'h6) ? rd_q[43:24] : rd_q[19:0];
        hs_d = hs_q;
        kind_d = kind_q;
        qc_d = (hs_q == HS_IDLE || tick) ? 7'h0 : qc_q + 7'h1;
        ph_d = ph_q;
        scl_d = scl_q;
        sdo_d = sdo_q;
        sh_d = sh_q;
        bit_d = bit_q;
        byte_d = byte_q;
        cmd_d = cmd_q;
        wd_d = wd_q;
        len_d = len_q;
        nack_d = nack_q;
        rd_d = rd_q;
        done_d = 1'b0;
        td_d = td_q;
        case (hs_q)
            HS_IDLE: begin
                scl_d = 1'b1;
                sdo_d = 1'b1;
                ph_d = 2'h0;
                if (req) begin
                    hs_d = HS_START;
                    kind_d = req_kind;
                    cmd_d = req_cmd;
                    wd_d = req_wdata;
                    len_d = req_len;
                    nack_d = 1'b0;
                    rd_d = 48'h0;
                    sh_d = {DEV_ADDR, req_kind == KD_READ};
                end
            end
            HS_START: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        sdo_d = 1'b0;
                    end
                    if (ph_q == 2'h3) begin
                        scl_d = 1'b0;
                        hs_d = HS_BIT;
                        bit_d = 4'h0;
                        byte_d = 3'h0;
                    end
                end
            end
            HS_BIT: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0: begin
                            if (bit_q != 4'h8) begin
                                sdo_d = wr ? sh_q[7] : 1'b1;
                            end else begin
                                sdo_d = wr | last;
                            end
                        end
                        2'h1: scl_d = 1'b1;
                        2'h2: begin
                            if (bit_q != 4'h8) begin
                                sh_d = {sh_q[6:0], s2};
                            end else if (wr && s2) begin
                                nack_d = 1'b1;
                            end
                        end
                        default: begin
                            scl_d = 1'b0;
                            if (bit_q != 4'h8) begin
                                bit_d = bit_q + 4'h1;
                            end else begin
                                if (!wr) begin
                                    rd_d = {rd_q[39:0], sh_q};
                                end
                                bit_d = 4'h0;
                                byte_d = byte_q + 3'h1;
                                sh_d = (byte_q == 3'h0) ? cmd_q : wd_q;
                                if (nack_q || last) begin
                                    hs_d = HS_STOP;
                                end
                            end
                        end
                    endcase
                end
            end
            HS_STOP: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0: sdo_d = 1'b0;
                        2'h1: scl_d = 1'b1;
                        2'h2: sdo_d = 1'b1;
                        default: begin
                            hs_d = HS_IDLE;
                            done_d = 1'b1;
                            if (kind_q == KD_READ) begin
                                td_d = $signed({{12{tv[RES_W-1]}}, tv}) / 32'sd100;
                            end
                        end
                    endcase
                end
            end
            default: hs_d = HS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hs_q <= HS_IDLE;
            kind_q <= KD_CMD;
            qc_q <= 7'h0;
            ph_q <= 2'h0;
            scl_q <= 1'b1;
            sdo_q <= 1'b1;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            byte_q <= 3'h0;
            cmd_q <= 8'h00;
            wd_q <= 8'h00;
            len_q <= 3'h0;
            nack_q <= 1'b0;
            rd_q <= 48'h0;
            done_q <= 1'b0;
            td_q <= 32'sd0;
            s1 <= 1'b1;
            s2 <= 1'b1;
        end else begin
            hs_q <= hs_d;
            kind_q <= kind_d;
            qc_q <= qc_d;
            ph_q <= ph_d;
            scl_q <= scl_d;
            sdo_q <= sdo_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            cmd_q <= cmd_d;
            wd_q <= wd_d;
            len_q <= len_d;
            nack_q <= nack_d;
            rd_q <= rd_d;
            done_q <= done_d;
            td_q <= td_d;
            s1 <= link.sda;
            s2 <= s1;
        end
    end

    assign link.scl = scl_q;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe_n = sdo_q;
    assign busy = (hs_q != HS_IDLE);
    assign done = done_q;
    assign nack = nack_q;
    assign rd_data = rd_q;
    assign temp_deg = td_q;
endmodule

// ---- sim/bsc_link_props.sv ----
`timescale 1ns/1ps
module bsc_link_props (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda_host_o,
    input wire logic sda_host_oe_n,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe_n,
    input wire logic sda
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_hi;
        scl [*8];
    endsequence
    sequence s_lo;
        !scl [*8];
    endsequence
    a_host_od_low: assert property ($fell(scl) |-> $stable(sda_host_oe_n))
        else $error("host data moved with clock fall");
    a_dev_od_low: assert property ($fell(sda_dev_oe_n) |-> !scl)
        else $error("device drive began while clock high");
    a_wire_and: assert property (sda == ((sda_host_oe_n | sda_host_o) &
        (sda_dev_oe_n | sda_dev_o)))
        else $error("data wire level wrong");
    a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe_n))
        else $error("device data moved while clock high");
    a_scl_high_min: assert property ($rose(scl) |-> s_hi)
        else $error("clock high phase too short");
    a_scl_low_min: assert property ($fell(scl) |-> s_lo)
        else $error("clock low phase too short");
    a_scl_low_max: assert property ($fell(scl) |-> ##[1:300] $rose(scl))
        else $error("clock low phase too long");
    a_start_free: assert property (scl && $fell(sda_host_oe_n) |-> sda_dev_oe_n)
        else $error("device drives at start");
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import bsc_pkg::*;
    logic ref_clk = 0;
    logic nrst = 0;
    logic req = 0;
    logic result_valid = 0;
    bsc_kind_t req_kind = KD_CMD;
    logic [7:0] req_cmd = 8'h00;
    logic [7:0] req_wdata = 8'h00;
    logic [2:0] req_len = 3'h1;
    logic [19:0] r_t = 20'h0_0000;
    logic [19:0] r_p = 20'h0_0000;
    logic [19:0] r_a = 20'h0_0000;
    logic conv_start, conv_temp_only, conv_fail, recal_busy, dev_ready, busy, done, nack;
    logic [2:0] conv_osr;
    logic [2:0] oversampling_ratio;
    logic [47:0] rd_data;
    logic signed [31:0] temp_deg;
    logic [31:0] seed = 32'h0000_003b;
    logic [7:0] mon_sh = 8'h00;
    logic [7:0] mon_addr = 8'h00;
    logic [5:0] ra;
    logic [7:0] m_img[$];
    logic [7:0] m_reg [64] = '{default: REG_RST};
    logic [7:0] rcmd [5] = '{CMD_P, CMD_A, CMD_T, CMD_TP, CMD_TA};
    int m_t = 0, m_p = 0, m_a = 0;
    int error_cnt = 0, samples_checked = 0, n_conv = 0, n_fail = 0, n_cal = 0, mon_n = 9, tv;
    bsc_link_if lk();
    always #2.5 ref_clk = ~ref_clk;
    bsc_dev #(.PWRUP_N(20), .CAL_N(10)) bsc_dev_i (.ref_clk, .nrst, .link(lk), .result_valid,
        .result_temp(r_t), .result_press(r_p), .result_alt(r_a), .conv_start, .conv_osr,
        .conv_temp_only, .conv_fail, .recal_busy, .dev_ready);
    bsc_host #(.QTR_N(10)) bsc_host_i (.ref_clk, .nrst, .link(lk), .req, .req_kind, .req_cmd,
        .req_wdata, .req_len, .busy, .done, .nack, .rd_data, .temp_deg);
    bsc_link_props bsc_link_props_i (.ref_clk, .nrst, .scl(lk.scl), .sda_host_o(lk.sda_host_o),
        .sda_host_oe_n(lk.sda_host_oe_n), .sda_dev_o(lk.sda_dev_o),
        .sda_dev_oe_n(lk.sda_dev_oe_n), .sda(lk.sda));
    always @(negedge ref_clk) begin
        if (conv_start === 1'b1) n_conv++;
        if (conv_fail === 1'b1) n_fail++;
        if (recal_busy === 1'b1) n_cal++;
    end
    // address byte seen on the wire after each start
    always @(negedge lk.sda) if (lk.scl === 1'b1) mon_n = 0;
    always @(posedge lk.scl) begin
        mon_sh = {mon_sh[6:0], lk.sda};
        mon_n++;
        if (mon_n == 8) mon_addr = mon_sh;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // model: a field is the sign-extended value, high byte first
    function automatic void m_put(int v);
        m_img.push_back(8'(v >>> 16));
        m_img.push_back(8'(v >>> 8));
        m_img.push_back(8'(v));
    endfunction
    function automatic void m_cmd(logic [7:0] c);
        if (c inside {CMD_P, CMD_A, CMD_T, CMD_TP, CMD_TA} || c[7:6] == REG_RD) begin
            m_img.delete();
        end
        if (c inside {CMD_T, CMD_TP, CMD_TA}) begin
            m_put(m_t);
        end
        if (c inside {CMD_P, CMD_TP}) begin
            m_put(m_p);
        end
        if (c inside {CMD_A, CMD_TA}) begin
            m_put(m_a);
        end
        if (c[7:6] == REG_RD) begin
            m_img.push_back(m_reg[c[5:0]]);
        end
        if (c == CMD_SRST) begin
            m_img.delete();
            m_reg = '{default: REG_RST};
        end
    endfunction
    task automatic rd_chk(string nm, logic [2:0] n);
        logic [47:0] e;
        e = '0;
        xfer(KD_READ, 8'h00, n);
        for (int j = 0; j < n; j++) begin
            e = {e[39:0], (j < m_img.size()) ? m_img[j] : 8'h00};
        end
        chk(nm, e, rd_data);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic xfer(bsc_kind_t k, logic [7:0] c, logic [2:0] n);
        int i;
        @(negedge ref_clk);
        req = 1;
        req_kind = k;
        req_cmd = c;
        req_len = n;
        req_wdata = 8'(xs());
        @(negedge ref_clk);
        req = 0;
        for (i = 0; i < 40000 && done !== 1'b1; i++) @(negedge ref_clk);
        if (done !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] done wait exp 1 got 0");
            complete_run();
        end
        chk("address byte", {DEV_ADDR, k == KD_READ}, mon_addr);
        chk("busy after done", 0, busy);
        $display("frame %h kind %0d done", c, k);
    endtask
    initial begin
        repeat (5) @(negedge ref_clk);
        nrst = 1;
        repeat (40) @(negedge ref_clk);
        chk("dev_ready", 1, dev_ready);
        r_t = 20'(xs());
        r_p = 20'(xs());
        r_a = 20'(xs());
        xfer(KD_CMD, CMD_CAL, 3'h1);
        chk("recal cycles", 10, n_cal);
        chk("ready after cal", 1, dev_ready);
        oversampling_ratio = 3'(1 + xs() % 5);
        xfer(KD_CMD, {CVT_PFX, oversampling_ratio, CH_T}, 3'h1);
        chk("conv_start count", 1, n_conv);
        chk("conv_osr", oversampling_ratio, conv_osr);
        chk("conv_temp_only", 1, conv_temp_only);
        @(negedge ref_clk);
        result_valid = 1;
        @(negedge ref_clk);
        result_valid = 0;
        m_t = {{12{r_t[19]}}, r_t};
        m_p = {{12{r_p[19]}}, r_p};
        m_a = {{12{r_a[19]}}, r_a};
        repeat (10) @(negedge ref_clk);
        xfer(KD_CMD, {CVT_PFX, 3'h6, CH_TP}, 3'h1);
        chk("conv_fail count", 1, n_fail);
        chk("conv_start after bad", 1, n_conv);
        xfer(KD_CMD, CMD_T, 3'h1);
        m_cmd(CMD_T);
        xfer(KD_READ, 8'h00, 3'h3);
        chk("temp field", {{4{r_t[19]}}, r_t}, rd_data[23:0]);
        tv = {{12{r_t[19]}}, r_t};
        chk("temp_deg", 48'(tv / 100), 48'(temp_deg));
        foreach (rcmd[k]) begin
            xfer(KD_CMD, rcmd[k], 3'h1);
            m_cmd(rcmd[k]);
            rd_chk("result image", 3'h6);
        end
        ra = 6'(xs());
        xfer(KD_WREG, {REG_WR, ra}, 3'h1);
        chk("nack reg write", 0, nack);
        m_reg[ra] = req_wdata;
        xfer(KD_CMD, {REG_RD, ra}, 3'h1);
        m_cmd({REG_RD, ra});
        rd_chk("reg read", 3'h1);
        xfer(KD_CMD, 8'h00, 3'h1);
        chk("nack undefined", 1, nack);
        chk("conv_osr kept", oversampling_ratio, conv_osr);
        rd_chk("kept after unknown", 3'h1);
        xfer(KD_CMD, CMD_SRST, 3'h1);
        chk("nack soft reset", 0, nack);
        chk("conv_osr cleared", 0, conv_osr);
        m_cmd(CMD_SRST);
        xfer(KD_CMD, {REG_RD, ra}, 3'h1);
        m_cmd({REG_RD, ra});
        rd_chk("reg after soft reset", 3'h1);
        complete_run();
    end
endmodule
